// file: hw/host_pio_fpdma_setup_receive.v
// host transport logic for received pio setup and first-party dma setup frames
// assumes link layer and dma engine on the same clock; apb slave per amba spec
//
// Chosen here: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "host_pio_regs.vh"

// Overview of operation
// R1 - one data frame follows each pio setup
// R2 - decode direction, mark last frame pio setup
// R3 - direction zero, no error: outbound prepare
// R4 - direction one, no error: idle, await data
// R5 - errored setup: report to link, idle
// R6 - link illegal transition forces idle
// R7 - outbound: load shadows, count, optional irq
// R8 - transmit only after shadows loaded, ready
// R9 - stay transmitting until link says done
// R10 - byte count reached: go to end
// R11 - soft/device reset: send sync, idle
// R12 - end: load ending status, then idle
// R13 - inbound errors reported to link layer
// R14 - device reports mid-command errors by register frame
// R15 - inbound: wait for frame and readable data
// R16 - data readable: load shadows, enter transfer
// R17 - inbound transfer waits for link completion
// R18 - dma setup programs controller, then idle
// R19 - errored dma setup: report, idle
// R20 - device sends dma activate later
// R21 - loopback request flagged when supported
// R22 - status bit7 busy, bit3 drq gate filling
module host_pio_fpdma_setup_receive (
   input wire clock,
   input wire resetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire frame_valid,
   input wire [1:0] frame_kind,
   input wire frame_err,
   input wire frame_dir,
   input wire frame_irq,
   input wire [7:0] frame_status,
   input wire [7:0] frame_end_status,
   input wire [15:0] frame_count,
   input wire [31:0] frame_regs,
   input wire [31:0] frame_dma_addr,
   input wire [31:0] frame_dma_len,
   input wire link_illegal,
   input wire link_rx_begin,
   input wire link_rx_word,
   input wire [31:0] link_rx_data,
   input wire link_rx_done,
   input wire link_rx_err,
   input wire link_tx_done,
   input wire dma_done,
   input wire bist_supported,
   output reg link_err_report,
   output reg link_send_sync,
   output reg link_tx_start,
   output reg tx_valid,
   output reg [31:0] tx_data,
   output reg dma_prog,
   output reg [31:0] dma_addr,
   output reg [31:0] dma_len,
   output reg bist_req
);

   // ************************************************************
   // states
   // ************************************************************
   localparam [2:0] host_transport_idle_state = 3'h0;
   localparam [2:0] ps_decode_state = 3'h1;
   localparam [2:0] pio_out_prepare_state = 3'h2;
   localparam [2:0] pio_out_transfer_state = 3'h3;
   localparam [2:0] pio_end_state = 3'h4;
   localparam [2:0] pio_in_wait_state = 3'h5;
   localparam [2:0] pio_in_transfer_state = 3'h6;
   localparam [2:0] dma_setup_state = 3'h7;

   function in_pio;
      input [2:0] st;
      begin
         in_pio = (st == pio_out_transfer_state) || (st == pio_in_wait_state) ||
            (st == pio_in_transfer_state);
      end
   endfunction

   function addr_ok;
      input [7:0] a;
      begin
         addr_ok = (a[1:0] == 2'h0) && (a <= `A_DMA);
      end
   endfunction

   reg [2:0] state_q;
   reg [7:0] sstat_q;
   reg [31:0] cmdblk_q;
   reg [15:0] count_q;
   reg [15:0] xfer_q;
   reg [7:0] init_status_q;
   reg [7:0] end_status_q;
   reg [31:0] regs_q;
   reg dir_q;
   reg irq_req_q;
   reg err_q;
   reg last_pio_q;
   reg irq_pend_q;
   reg srst_q;
   reg avail_q;
   reg [31:0] rx_data_q;

   // ************************************************************
   // apb decode
   // ************************************************************
   wire done = psel & penable & pready;
   wire wr = done & pwrite & addr_ok(paddr);
   wire rd = done & ~pwrite & addr_ok(paddr);
   wire wr_ctrl = wr & (paddr == `A_CTRL);
   wire devrst = wr_ctrl & pwdata[`CTRL_DEVRST];
   wire abort = srst_q | devrst;
   wire fill_ok = sstat_q[`STAT_DRQ] & ~sstat_q[`STAT_BSY]; // R22
   wire sw_push = wr & (paddr == `A_DATA) & (state_q == pio_out_transfer_state) & fill_ok;
   wire sw_pop = rd & (paddr == `A_DATA);
   wire count_hit = (xfer_q == count_q);
   wire [7:0] state_word = {err_q, dir_q, last_pio_q, irq_pend_q, 1'b0, state_q};

   always @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
      end
      else
      begin
         pready <= psel & penable & ~pready;
         pslverr <= psel & penable & ~pready & ~addr_ok(paddr);
         if (psel & penable & ~pready)
         begin
            case (paddr)
               `A_CTRL: prdata <= {31'h00000000, srst_q};
               `A_SSTAT: prdata <= {24'h000000, sstat_q};
               `A_DATA: prdata <= rx_data_q;
               `A_CMDBLK: prdata <= cmdblk_q;
               `A_COUNT: prdata <= {16'h0000, count_q};
               `A_STATE: prdata <= {23'h000000, avail_q, state_word};
               `A_XFER: prdata <= {16'h0000, xfer_q};
               `A_DMA: prdata <= dma_addr;
               default: prdata <= 32'h00000000;
            endcase
         end
      end
   end

   // ************************************************************
   // software controls
   // ************************************************************
   always @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         srst_q <= 1'b0;
      end
      else if (wr_ctrl)
      begin
         srst_q <= pwdata[`CTRL_SRST];
      end
   end

   // inbound data word, link set wins over software read
   always @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         avail_q <= 1'b0;
         rx_data_q <= 32'h00000000;
      end
      else if (link_rx_word && (state_q == pio_in_wait_state ||
         state_q == pio_in_transfer_state))
      begin
         avail_q <= 1'b1;
         rx_data_q <= link_rx_data;
      end
      else if (sw_pop || state_q == host_transport_idle_state)
      begin
         avail_q <= 1'b0;
      end
   end

   // ************************************************************
   // transport state machine
   // ************************************************************
   always @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         state_q <= host_transport_idle_state;
         sstat_q <= `SSTAT_RST;
         cmdblk_q <= `CMDBLK_RST;
         count_q <= 16'h0000;
         xfer_q <= 16'h0000;
         init_status_q <= 8'h00;
         end_status_q <= 8'h00;
         regs_q <= 32'h00000000;
         dir_q <= 1'b0;
         irq_req_q <= 1'b0;
         err_q <= 1'b0;
         last_pio_q <= 1'b0;
         irq_pend_q <= 1'b0;
         link_err_report <= 1'b0;
         link_send_sync <= 1'b0;
         link_tx_start <= 1'b0;
         tx_valid <= 1'b0;
         tx_data <= 32'h00000000;
         dma_prog <= 1'b0;
         dma_addr <= 32'h00000000;
         dma_len <= 32'h00000000;
         bist_req <= 1'b0;
      end
      else
      begin
         link_err_report <= 1'b0;
         link_send_sync <= 1'b0;
         link_tx_start <= 1'b0;
         tx_valid <= 1'b0;
         bist_req <= 1'b0;
         // software clears pending irq by writing one, set wins
         if (wr && paddr == `A_STATE && pwdata[`ST_IRQP])
         begin
            irq_pend_q <= 1'b0;
         end
         if (sw_push)
         begin
            tx_valid <= 1'b1;
            tx_data <= pwdata;
            xfer_q <= xfer_q + `WORD_BYTES;
         end
         if (link_rx_word && (state_q == pio_in_wait_state ||
            state_q == pio_in_transfer_state))
         begin
            xfer_q <= xfer_q + `WORD_BYTES;
         end
         if (link_rx_err && in_pio(state_q))
         begin
            err_q <= 1'b1;
         end
         if (link_illegal && state_q != host_transport_idle_state)
         begin
            state_q <= host_transport_idle_state; // R6
            dma_prog <= 1'b0;
         end
         else if (abort && in_pio(state_q))
         begin
            link_send_sync <= 1'b1; // R11
            state_q <= host_transport_idle_state;
            last_pio_q <= 1'b0;
         end
         else
         begin
            case (state_q)
               host_transport_idle_state:
               begin
                  if (frame_valid)
                  begin
                     err_q <= frame_err;
                     case (frame_kind)
                        `KIND_PIO:
                        begin
                           dir_q <= frame_dir;
                           irq_req_q <= frame_irq;
                           init_status_q <= frame_status;
                           end_status_q <= frame_end_status;
                           count_q <= frame_count;
                           regs_q <= frame_regs;
                           state_q <= ps_decode_state;
                        end
                        `KIND_DMA:
                        begin
                           dma_addr <= frame_dma_addr;
                           dma_len <= frame_dma_len;
                           state_q <= dma_setup_state;
                        end
                        `KIND_BIST:
                        begin
                           bist_req <= ~frame_err & bist_supported; // R21
                        end
                        default:
                        begin
                           state_q <= host_transport_idle_state;
                        end
                     endcase
                  end
                  else if (link_rx_begin && last_pio_q && dir_q)
                  begin
                     xfer_q <= 16'h0000; // R15
                     err_q <= 1'b0;
                     state_q <= pio_in_wait_state; // R1
                  end
               end
               ps_decode_state:
               begin
                  last_pio_q <= ~err_q; // R2
                  xfer_q <= 16'h0000;
                  if (err_q)
                  begin
                     link_err_report <= 1'b1; // R5
                     state_q <= host_transport_idle_state;
                  end
                  else if (!dir_q)
                  begin
                     state_q <= pio_out_prepare_state; // R3
                  end
                  else
                  begin
                     state_q <= host_transport_idle_state; // R4
                  end
               end
               pio_out_prepare_state:
               begin
                  cmdblk_q <= regs_q; // R7
                  sstat_q <= init_status_q;
                  if (irq_req_q)
                  begin
                     irq_pend_q <= 1'b1;
                  end
                  link_tx_start <= 1'b1; // R8
                  state_q <= pio_out_transfer_state;
               end
               pio_out_transfer_state:
               begin
                  if (link_tx_done && count_hit)
                  begin
                     state_q <= pio_end_state; // R9 R10
                  end
               end
               pio_in_wait_state:
               begin
                  if (avail_q)
                  begin
                     cmdblk_q <= regs_q; // R16
                     sstat_q <= init_status_q;
                     if (irq_req_q)
                     begin
                        irq_pend_q <= 1'b1;
                     end
                     state_q <= pio_in_transfer_state;
                  end
               end
               pio_in_transfer_state:
               begin
                  if (link_rx_done && count_hit)
                  begin
                     state_q <= pio_end_state; // R17 R10
                  end
               end
               pio_end_state:
               begin
                  sstat_q <= end_status_q; // R12
                  link_err_report <= err_q & dir_q; // R13
                  last_pio_q <= 1'b0;
                  state_q <= host_transport_idle_state;
               end
               dma_setup_state:
               begin
                  if (err_q)
                  begin
                     link_err_report <= 1'b1; // R19
                     state_q <= host_transport_idle_state;
                  end
                  else if (dma_prog && dma_done)
                  begin
                     dma_prog <= 1'b0; // R18
                     state_q <= host_transport_idle_state;
                  end
                  else
                  begin
                     dma_prog <= 1'b1; // R18
                  end
               end
               default:
               begin
                  state_q <= host_transport_idle_state;
               end
            endcase
         end
      end
   end

endmodule
`default_nettype wire

// file: hw/host_pio_regs.vh
// register map, field positions and codes of the pio/dma setup receiver
// assumes a 32-bit apb slave with 8-bit byte address
`ifndef HOST_PIO_REGS_VH
`define HOST_PIO_REGS_VH
`define A_CTRL 8'h00
`define A_SSTAT 8'h04
`define A_DATA 8'h08
`define A_CMDBLK 8'h0C
`define A_COUNT 8'h10
`define A_STATE 8'h14
`define A_XFER 8'h18
`define A_DMA 8'h1C
`define CTRL_SRST 0
`define CTRL_DEVRST 1
`define STAT_BSY 7
`define STAT_DRQ 3
`define ST_IRQP 4
`define ST_LASTPIO 5
`define ST_DIR 6
`define ST_ERR 7
`define KIND_PIO 2'h1
`define KIND_DMA 2'h2
`define KIND_BIST 2'h3
`define WORD_BYTES 16'h0004
`define SSTAT_RST 8'h00
`define CMDBLK_RST 32'h00000000
`endif

// file: bench/setup_receive_props.sv
// checker for the pio/dma setup receiver, watching top-level ports only
// assumes the register map header and a single clock domain
`timescale 1ns/1ps
`default_nettype none
`include "host_pio_regs.vh"
module setup_receive_props (
   input wire logic clock,
   input wire logic resetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic frame_valid,
   input wire logic [1:0] frame_kind,
   input wire logic frame_err,
   input wire logic frame_dir,
   input wire logic bist_supported,
   input wire logic link_illegal,
   input wire logic dma_done,
   input wire logic link_err_report,
   input wire logic link_tx_start,
   input wire logic tx_valid,
   input wire logic [31:0] tx_data,
   input wire logic dma_prog,
   input wire logic bist_req
);
   // ****
   // properties
   // ****
   default clocking @(posedge clock); endclocking
   default disable iff (!resetn);
   sequence pio_out_take;
      frame_valid && frame_kind == `KIND_PIO && !frame_err && !frame_dir;
   endsequence
   sequence pio_in_take;
      frame_valid && frame_kind == `KIND_PIO && !frame_err && frame_dir;
   endsequence
   sequence bist_take;
      frame_valid && frame_kind == `KIND_BIST && !frame_err;
   endsequence
   apb_wait_a: assert property (psel && penable && !pready |=> pready)
      else $error("pready late");
   err_with_ready_a: assert property (pslverr |-> pready && psel && penable)
      else $error("pslverr outside access");
   pio_err_rep_a: assert property (frame_valid && frame_kind == `KIND_PIO && frame_err
      |-> ##[1:2] link_err_report) else $error("pio error not reported");
   dma_err_rep_a: assert property (frame_valid && frame_kind == `KIND_DMA && frame_err
      |-> ##[1:2] link_err_report) else $error("dma error not reported");
   out_start_a: assert property (pio_out_take |-> ##[2:4] link_tx_start)
      else $error("no outbound start");
   in_quiet_a: assert property (pio_in_take |-> (!link_tx_start) [*5])
      else $error("outbound start on inbound");
   dma_go_a: assert property (frame_valid && frame_kind == `KIND_DMA && !frame_err
      |-> ##[1:3] dma_prog) else $error("dma not programmed");
   prog_hold_a: assert property (dma_prog && !dma_done |=> dma_prog)
      else $error("dma_prog dropped early");
   prog_drop_a: assert property (dma_prog && dma_done |=> !dma_prog)
      else $error("dma_prog stuck");
   tx_word_a: assert property (tx_valid |-> $past(psel && penable && pready && pwrite)
      && $past(paddr) == `A_DATA && tx_data == $past(pwdata)) else $error("bad tx word");
   bist_on_a: assert property (bist_take and bist_supported |=> bist_req)
      else $error("bist not requested");
   bist_off_a: assert property (bist_take and !bist_supported |=> !bist_req)
      else $error("unsupported bist requested");
   illegal_a: assert property (link_illegal |-> ##[1:2] !dma_prog && !link_tx_start)
      else $error("illegal not honoured");
endmodule
bind host_pio_fpdma_setup_receive setup_receive_props props_inst (
   .clock(clock), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
   .frame_valid(frame_valid), .frame_kind(frame_kind), .frame_err(frame_err),
   .frame_dir(frame_dir), .bist_supported(bist_supported), .link_illegal(link_illegal),
   .dma_done(dma_done), .link_err_report(link_err_report), .link_tx_start(link_tx_start),
   .tx_valid(tx_valid), .tx_data(tx_data), .dma_prog(dma_prog), .bist_req(bist_req));
`default_nettype wire

// file: bench/link_far_model.sv
// far side: link layer reporting outbound completion, dma engine taking a program
// assumes the receiver's clock; dma_slow picks a slow engine
`timescale 1ns/1ps
`default_nettype none
module link_far_model (
   input wire logic clock,
   input wire logic resetn,
   input wire logic link_tx_start,
   input wire logic tx_valid,
   input wire logic dma_prog,
   input wire logic dma_slow,
   input wire logic [15:0] exp_bytes,
   output logic link_tx_done,
   output logic dma_done
);
   logic [15:0] got_q;
   logic [3:0] wait_q;
   always @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         got_q <= 16'h0;
         wait_q <= 4'h0;
         link_tx_done <= 1'b0;
         dma_done <= 1'b0;
      end
      else
      begin
         link_tx_done <= tx_valid && (got_q + 16'h4 == exp_bytes);
         if (link_tx_start)
            got_q <= 16'h0;
         else if (tx_valid)
            got_q <= got_q + 16'h4;
         dma_done <= dma_prog && !dma_done && wait_q == (dma_slow ? 4'h6 : 4'h0);
         if (dma_prog && !dma_done && wait_q != (dma_slow ? 4'h6 : 4'h0))
            wait_q <= wait_q + 4'h1;
         else
            wait_q <= 4'h0;
      end
   end
endmodule
`default_nettype wire

// file: bench/tb_host_pio_fpdma_setup_receive.sv
// self-checking bench for the pio/dma setup receiver
// assumes the far-side model and the checker bound to the receiver
`timescale 1ns/1ps
`default_nettype none
`include "host_pio_regs.vh"
module tb_host_pio_fpdma_setup_receive;
   localparam logic [31:0] REGS = 32'hA5A5_1234;
   localparam logic [31:0] DADDR = 32'h8000_0040;
   localparam logic [7:0] END_ST = 8'h50;
   logic clock = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic frame_valid = 1'b0, frame_err = 1'b0, frame_dir = 1'b0, frame_irq = 1'b0;
   logic link_illegal = 1'b0, link_rx_begin = 1'b0, link_rx_word = 1'b0;
   logic link_rx_done = 1'b0, link_rx_err = 1'b0, bist_supported = 1'b0, dma_slow = 1'b0;
   logic [1:0] frame_kind = 2'h0;
   logic [7:0] paddr = 8'h0, frame_status = 8'h0, frame_end_status = 8'h0;
   logic [15:0] frame_count = 16'h0, exp_bytes = 16'h0;
   logic [31:0] pwdata = '0, frame_regs = '0, frame_dma_addr = '0, frame_dma_len = '0;
   logic [31:0] link_rx_data = '0, prdata, tx_data, dma_addr, dma_len, rd;
   logic pready, pslverr, link_tx_done, dma_done, link_err_report, link_send_sync;
   logic link_tx_start, tx_valid, dma_prog, bist_req, rerr;
   int n_errors = 0, check_count = 0, n_rep = 0, n_sync = 0, n_start = 0, n_bist = 0;
   int cyc = 0, i;
   always #2.5 clock = ~clock;
   host_pio_fpdma_setup_receive host_pio_fpdma_setup_receive_inst (
      .clock(clock), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .frame_valid(frame_valid), .frame_kind(frame_kind), .frame_err(frame_err),
      .frame_dir(frame_dir), .frame_irq(frame_irq), .frame_status(frame_status),
      .frame_end_status(frame_end_status), .frame_count(frame_count),
      .frame_regs(frame_regs), .frame_dma_addr(frame_dma_addr), .frame_dma_len(frame_dma_len),
      .link_illegal(link_illegal), .link_rx_begin(link_rx_begin), .link_rx_word(link_rx_word),
      .link_rx_data(link_rx_data), .link_rx_done(link_rx_done), .link_rx_err(link_rx_err),
      .link_tx_done(link_tx_done), .dma_done(dma_done), .bist_supported(bist_supported),
      .link_err_report(link_err_report), .link_send_sync(link_send_sync),
      .link_tx_start(link_tx_start), .tx_valid(tx_valid), .tx_data(tx_data),
      .dma_prog(dma_prog), .dma_addr(dma_addr), .dma_len(dma_len), .bist_req(bist_req));
   link_far_model link_far_model_inst (
      .clock(clock), .resetn(resetn), .link_tx_start(link_tx_start), .tx_valid(tx_valid),
      .dma_prog(dma_prog), .dma_slow(dma_slow), .exp_bytes(exp_bytes),
      .link_tx_done(link_tx_done), .dma_done(dma_done));
   // ****
   // tasks
   // ****
   task wrap_up;
   begin
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   end
   endtask
   task check(input [31:0] seen, input [31:0] exp);
   begin
      check_count++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("Error at %0t: got %h expected %h", $time, seen, exp);
      end
   end
   endtask
   task apb(input [7:0] a, input w, input [31:0] d);
   begin
      @(posedge clock);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      @(posedge clock);
      while (pready !== 1'b1)
         @(posedge clock);
      rd = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   end
   endtask
   task wait_st(input [2:0] s);
      int n;
   begin
      n = 0;
      rd = 32'hFFFF_FFFF;
      while (rd[2:0] !== s && n < 30)
      begin
         apb(`A_STATE, 1'b0, 32'h0);
         n++;
      end
      check({29'h0, rd[2:0]}, {29'h0, s});
   end
   endtask
   // released fields show inverted data
   task frame(input [1:0] k, input e, input d, input [15:0] c);
   begin
      @(posedge clock);
      frame_valid <= 1'b1;
      {frame_kind, frame_err, frame_dir, frame_count} <= {k, e, d, c};
      {frame_irq, frame_status, frame_end_status} <= {1'b1, 8'h08, END_ST};
      {frame_regs, frame_dma_addr, frame_dma_len} <= {REGS, DADDR, 32'h0000_0200};
      @(posedge clock);
      frame_valid <= 1'b0;
      {frame_kind, frame_err, frame_dir, frame_count} <= ~{k, e, d, c};
      {frame_irq, frame_status, frame_end_status} <= ~{1'b1, 8'h08, END_ST};
      {frame_regs, frame_dma_addr, frame_dma_len} <= ~{REGS, DADDR, 32'h0000_0200};
   end
   endtask
   task lpulse(input [3:0] m, input [31:0] d);
   begin
      @(posedge clock);
      {link_illegal, link_rx_done, link_rx_word, link_rx_begin} <= m;
      link_rx_data <= d;
      @(posedge clock);
      {link_illegal, link_rx_done, link_rx_word, link_rx_begin} <= 4'h0;
      link_rx_data <= ~d;
   end
   endtask
   always @(posedge clock)
   begin
      n_rep += (link_err_report === 1'b1);
      n_sync += (link_send_sync === 1'b1);
      n_start += (link_tx_start === 1'b1);
      n_bist += (bist_req === 1'b1);
      cyc++;
      if (cyc == 4000)
      begin
         n_errors++;
         wrap_up;
      end
   end
   // ****
   // tests
   // ****
   initial
   begin
      repeat (2) @(posedge clock);
      resetn <= 1'b1;
      apb(`A_SSTAT, 1'b0, 32'h0);
      check(rd, {24'h0, `SSTAT_RST});
      for (i = 0; i < 2; i++)
      begin
         apb(i ? 8'h06 : 8'h20, 1'b0, 32'h0);
         check({rd[30:0], rerr}, 32'h1);
      end
      exp_bytes <= 16'h0008;
      frame(`KIND_PIO, 1'b0, 1'b0, 16'h0008);
      wait_st(3'h3);
      apb(`A_STATE, 1'b0, 32'h0);
      check({29'h0, rd[6:4]}, 32'h3);
      apb(`A_CMDBLK, 1'b0, 32'h0);
      check(rd, REGS);
      apb(`A_COUNT, 1'b0, 32'h0);
      check(rd, 32'h8);
      apb(`A_DATA, 1'b1, 32'h1111_0001);
      wait_st(3'h3);
      apb(`A_DATA, 1'b1, 32'h2222_0002);
      wait_st(3'h0);
      apb(`A_SSTAT, 1'b0, 32'h0);
      check(rd, {24'h0, END_ST});
      apb(`A_XFER, 1'b0, 32'h0);
      check(rd, 32'h8);
      frame(`KIND_PIO, 1'b0, 1'b0, 16'h0010);
      wait_st(3'h3);
      apb(`A_CTRL, 1'b1, 32'h1);
      wait_st(3'h0);
      apb(`A_CTRL, 1'b1, 32'h0);
      check(n_sync, 32'h1);
      frame(`KIND_PIO, 1'b0, 1'b0, 16'h0010);
      wait_st(3'h3);
      lpulse(4'h8, 32'h0);
      wait_st(3'h0);
      check(n_sync, 32'h1);
      frame(`KIND_PIO, 1'b0, 1'b1, 16'h0008);
      apb(`A_STATE, 1'b0, 32'h0);
      check({27'h0, rd[6:5], rd[2:0]}, 32'h18);
      lpulse(4'h1, 32'h0);
      wait_st(3'h5);
      lpulse(4'h2, 32'hCAFE_0001);
      wait_st(3'h6);
      apb(`A_CMDBLK, 1'b0, 32'h0);
      check(rd, REGS);
      apb(`A_DATA, 1'b0, 32'h0);
      check(rd, 32'hCAFE_0001);
      link_rx_err <= 1'b1;
      lpulse(4'h2, 32'hCAFE_0002);
      wait_st(3'h6);
      lpulse(4'h4, 32'h0);
      wait_st(3'h0);
      link_rx_err <= 1'b0;
      check(n_rep, 32'h1);
      frame(2'h0, 1'b0, 1'b0, 16'h0008);
      wait_st(3'h0);
      frame(`KIND_PIO, 1'b0, 1'b1, 16'h0008);
      lpulse(4'h1, 32'h0);
      wait_st(3'h5);
      apb(`A_CTRL, 1'b1, 32'h2);
      wait_st(3'h0);
      check(n_sync, 32'h2);
      for (i = 1; i < 3; i++)
      begin
         frame(i[1:0], 1'b1, 1'b0, 16'h0008);
         wait_st(3'h0);
      end
      check(n_rep, 32'h3);
      check(n_start, 32'h3);
      for (i = 0; i < 2; i++)
      begin
         dma_slow <= ~i[0];
         frame(`KIND_DMA, 1'b0, 1'b0, 16'h0);
         wait_st(3'h0);
         check(dma_addr, DADDR);
         check(dma_len, 32'h0000_0200);
      end
      apb(`A_DMA, 1'b0, 32'h0);
      check(rd, DADDR);
      bist_supported <= 1'b1;
      frame(`KIND_BIST, 1'b0, 1'b0, 16'h0);
      bist_supported <= 1'b0;
      frame(`KIND_BIST, 1'b0, 1'b0, 16'h0);
      wait_st(3'h0);
      check(n_bist, 32'h1);
      wrap_up;
   end
endmodule
`default_nettype wire
